//--- i2cm_engine.sv
// Purpose: bit-level i2c frame engine, stepped by the 400 kHz tick
// Assumes: each tick is one quarter of a bus bit time
// Notes: scl and sda are open drain; oe low means pull the line low
`timescale 1ns/10ps
`include "i2cm_map.svh"

module i2cm_engine
  import i2cm_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_tick,
  input wire logic i_go,
  input wire i2cm_job_t i_job,
  input wire logic i_sda,
  output logic o_scl_oe_n,
  output logic o_sda_oe_n,
  output i2cm_res_t o_res
);

  // -----------------------------------------------------------------
  // frame sequencer
  // -----------------------------------------------------------------
  i2cm_st_t st_r;
  logic [1:0] ph_r;
  logic [2:0] bit_r;
  logic [1:0] byte_r;
  logic [7:0] sh_r;
  logic scl_lo_r;
  logic sda_lo_r;
  logic last_byte;

  assign last_byte = (byte_r == 2'd2) || (byte_r == 2'd1 && !i_job.two);
  assign o_scl_oe_n = scl_lo_r;
  assign o_sda_oe_n = sda_lo_r;

  // frame: start, address+dir, one or two bytes, acks, stop
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      st_r <= I2CM_IDLE;
      ph_r <= 2'd0;
      bit_r <= 3'd0;
      byte_r <= 2'd0;
      sh_r <= `I2CM_RST_BYTE;
      scl_lo_r <= 1'b1;
      sda_lo_r <= 1'b1;
      o_res <= '0;
    end
    else
    begin
      o_res.done <= 1'b0;
      o_res.rx0_vld <= 1'b0;
      o_res.rx1_vld <= 1'b0;
      if (i_go && st_r == I2CM_IDLE)
      begin
        st_r <= I2CM_START;
        ph_r <= 2'd0;
        o_res.busy <= 1'b1;
        o_res.ack_err <= 1'b0;
        byte_r <= 2'd0;
        sh_r <= {i_job.addr, i_job.dir};
      end
      else if (i_tick)
      begin
        ph_r <= ph_r + 2'd1;
        case (st_r)
          I2CM_START:
          begin
            if (ph_r == 2'd1)
              sda_lo_r <= 1'b0;
            if (ph_r == 2'd3)
            begin
              scl_lo_r <= 1'b0;
              st_r <= I2CM_BIT;
              bit_r <= 3'd7;
            end
          end
          I2CM_BIT:
          begin
            // reads drive sda released after the address byte
            if (ph_r == 2'd0)
              sda_lo_r <= (byte_r != 2'd0 && i_job.dir) ? 1'b1 : sh_r[7];
            if (ph_r == 2'd1)
              scl_lo_r <= 1'b1;
            if (ph_r == 2'd2)
              sh_r <= {sh_r[6:0], i_sda};
            if (ph_r == 2'd3)
            begin
              scl_lo_r <= 1'b0;
              bit_r <= bit_r - 3'd1;
              if (bit_r == 3'd0)
                st_r <= I2CM_ACK;
            end
          end
          I2CM_ACK:
          begin
            if (ph_r == 2'd0)
            begin
              if (byte_r != 2'd0 && i_job.dir)
                sda_lo_r <= last_byte; // no ack on last read byte
              else
                sda_lo_r <= 1'b1;
              if (byte_r == 2'd1 && i_job.dir)
              begin
                o_res.rx <= sh_r;
                o_res.rx0_vld <= 1'b1;
              end
              if (byte_r == 2'd2 && i_job.dir)
              begin
                o_res.rx <= sh_r;
                o_res.rx1_vld <= 1'b1;
              end
            end
            if (ph_r == 2'd1)
              scl_lo_r <= 1'b1;
            if (ph_r == 2'd2 && !(byte_r != 2'd0 && i_job.dir) && i_sda)
              o_res.ack_err <= 1'b1;
            if (ph_r == 2'd3)
            begin
              scl_lo_r <= 1'b0;
              bit_r <= 3'd7;
              byte_r <= byte_r + 2'd1;
              if (o_res.ack_err || (byte_r != 2'd0 && last_byte))
                st_r <= I2CM_STOP;
              else
              begin
                st_r <= I2CM_BIT;
                sh_r <= (byte_r == 2'd0) ? i_job.tx0 : i_job.tx1;
              end
            end
          end
          I2CM_STOP:
          begin
            if (ph_r == 2'd0)
              sda_lo_r <= 1'b0;
            if (ph_r == 2'd1)
              scl_lo_r <= 1'b1;
            if (ph_r == 2'd2)
              sda_lo_r <= 1'b1;
            if (ph_r == 2'd3)
              st_r <= I2CM_END;
          end
          I2CM_END:
          begin
            st_r <= I2CM_IDLE;
            o_res.busy <= 1'b0;
            o_res.done <= 1'b1;
          end
          default:
            ph_r <= 2'd0;
        endcase
      end
    end
  end

endmodule : i2cm_engine

//--- i2cm_map.svh
// Purpose: register map, field positions and timing for the i2c master
// Assumes: byte-wide special function register port on the system clock
// Notes: offsets are full register addresses
`ifndef I2CM_MAP_SVH
`define I2CM_MAP_SVH

`define I2CM_ADDR_SLAVE 16'hFF80
`define I2CM_ADDR_TX0 16'hFF81
`define I2CM_ADDR_TX1 16'hFF82
`define I2CM_ADDR_RX0 16'hFF83
`define I2CM_ADDR_RX1 16'hFF84
`define I2CM_ADDR_CSR 16'hFF85
`define I2CM_ADDR_INT6 16'hFF95

`define I2CM_RST_BYTE 8'h00

`define I2CM_CSR_LEN 0
`define I2CM_CSR_START 1
`define I2CM_CSR_ACK_ERROR_FLAG 2
`define I2CM_INT6_FLAG 2
`define I2CM_INT6_IEN 3
`define I2CM_SLAVE_DIR 0

`define I2CM_BUS_KHZ 400
`define I2CM_CLK_MHZ 100
`define I2CM_QTR_MAX 8'h3F

`endif

//--- i2cm_pkg.sv
// Purpose: shared types for the i2c master
// Assumes: no header is included; widths are fixed in the types
// Notes: none
package i2cm_pkg;

  typedef struct packed {
    logic [6:0] addr;
    logic dir;
    logic two;
    logic [7:0] tx0;
    logic [7:0] tx1;
  } i2cm_job_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic ack_err;
    logic rx0_vld;
    logic rx1_vld;
    logic [7:0] rx;
  } i2cm_res_t;

  typedef enum logic [3:0] {
    I2CM_IDLE,
    I2CM_START,
    I2CM_BIT,
    I2CM_ACK,
    I2CM_STOP,
    I2CM_END
  } i2cm_st_t;

endpackage : i2cm_pkg

//--- i2cm_top.sv
// Purpose: register file and bus master wrapper for the i2c master
// Assumes: byte register port on the system clock, 400 kHz quarter tick
// Notes: interrupt level goes to external interrupt source 6
`timescale 1ns/10ps
`include "i2cm_map.svh"

// Function
// - master only, standard mode 100 kHz (four 400 kHz ticks per bit)
// - bus timing from time-base 400 kHz tick
// - one or two bytes each direction
// - six dedicated control registers
// - address register: 7-bit address, direction bit
// - control/status configures, starts, reports errors
// - writing bit 1 starts transaction
// - length bit adds secondary write byte
// - received bytes land in read registers
// - completion raises interrupt source 6
// - next start clears completion interrupt
// - csr at 0xFF85: len, start, ack error
module i2cm_top
  import i2cm_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_tick_400k,
  input wire logic [15:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_scl_oe_n,
  output logic o_sda,
  output logic o_sda_oe_n,
  output logic o_int6
);

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  logic [7:0] slave_address_reg_r;
  logic [7:0] primary_tx_byte_r;
  logic [7:0] secondary_tx_byte_r;
  logic [7:0] primary_rx_byte_r;
  logic [7:0] secondary_rx_byte_r;
  logic two_byte_select_r;
  logic bus_master_irq_enable_r;
  logic bus_master_irq_flag_r;
  logic go;
  i2cm_job_t job;
  i2cm_res_t res;

  assign o_scl = 1'b0;
  assign o_sda = 1'b0;

  // start from bit 1 of the control/status write
  assign go = i_reg_wr && (i_reg_addr == `I2CM_ADDR_CSR)
    && i_reg_wdata[`I2CM_CSR_START] && !res.busy;

  assign job.addr = slave_address_reg_r[7:1];
  assign job.dir = slave_address_reg_r[`I2CM_SLAVE_DIR];
  assign job.two = two_byte_select_r;
  assign job.tx0 = primary_tx_byte_r;
  assign job.tx1 = secondary_tx_byte_r;

  // five writable registers: slave, tx0, tx1, csr length, int6 enable
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      slave_address_reg_r <= `I2CM_RST_BYTE;
      primary_tx_byte_r <= `I2CM_RST_BYTE;
      secondary_tx_byte_r <= `I2CM_RST_BYTE;
      two_byte_select_r <= 1'b0;
      bus_master_irq_enable_r <= 1'b0;
    end
    else if (i_reg_wr && !res.busy)
    begin
      case (i_reg_addr)
        `I2CM_ADDR_SLAVE: slave_address_reg_r <= i_reg_wdata;
        `I2CM_ADDR_TX0: primary_tx_byte_r <= i_reg_wdata;
        `I2CM_ADDR_TX1: secondary_tx_byte_r <= i_reg_wdata;
        `I2CM_ADDR_CSR:
          two_byte_select_r <= i_reg_wdata[`I2CM_CSR_LEN];
        `I2CM_ADDR_INT6:
          bus_master_irq_enable_r <= i_reg_wdata[`I2CM_INT6_IEN];
        default: two_byte_select_r <= two_byte_select_r;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // receive capture
  // -----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      primary_rx_byte_r <= `I2CM_RST_BYTE;
      secondary_rx_byte_r <= `I2CM_RST_BYTE;
    end
    else
    begin
      if (res.rx0_vld)
        primary_rx_byte_r <= res.rx;
      if (res.rx1_vld && two_byte_select_r)
        secondary_rx_byte_r <= res.rx;
    end
  end

  // -----------------------------------------------------------------
  // completion flag, set wins over clear
  // -----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      bus_master_irq_flag_r <= 1'b0;
    else if (res.done)
      bus_master_irq_flag_r <= 1'b1;
    else if (go)
      bus_master_irq_flag_r <= 1'b0;
  end

  assign o_int6 = bus_master_irq_flag_r && bus_master_irq_enable_r;

  // -----------------------------------------------------------------
  // read mux
  // -----------------------------------------------------------------
  always_comb
  begin
    o_reg_rdata = `I2CM_RST_BYTE;
    if (i_reg_rd)
    begin
      case (i_reg_addr)
        `I2CM_ADDR_SLAVE: o_reg_rdata = slave_address_reg_r;
        `I2CM_ADDR_TX0: o_reg_rdata = primary_tx_byte_r;
        `I2CM_ADDR_TX1: o_reg_rdata = secondary_tx_byte_r;
        `I2CM_ADDR_RX0: o_reg_rdata = primary_rx_byte_r;
        `I2CM_ADDR_RX1: o_reg_rdata = secondary_rx_byte_r;
        `I2CM_ADDR_CSR:
        begin
          o_reg_rdata[`I2CM_CSR_LEN] = two_byte_select_r;
          o_reg_rdata[`I2CM_CSR_START] = res.busy;
          o_reg_rdata[`I2CM_CSR_ACK_ERROR_FLAG] = res.ack_err;
        end
        `I2CM_ADDR_INT6:
        begin
          o_reg_rdata[`I2CM_INT6_IEN] = bus_master_irq_enable_r;
          o_reg_rdata[`I2CM_INT6_FLAG] = bus_master_irq_flag_r;
        end
        default: o_reg_rdata = `I2CM_RST_BYTE;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // bus engine, master only on the 400 kHz tick
  // -----------------------------------------------------------------
  i2cm_engine u_engine (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_tick(i_tick_400k),
    .i_go(go),
    .i_job(job),
    .i_sda(i_sda),
    .o_scl_oe_n(o_scl_oe_n),
    .o_sda_oe_n(o_sda_oe_n),
    .o_res(res)
  );

endmodule : i2cm_top

//--- i2cm_asserts.sv
// Purpose: port-level checker for the i2c master
// Assumes: register map header, one clock domain
// Notes: attached by bind from the testbench
`timescale 1ns/10ps
`include "i2cm_map.svh"
module i2cm_asserts
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_tick_400k,
  input wire logic [15:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_scl,
  input wire logic o_scl_oe_n,
  input wire logic o_sda,
  input wire logic o_sda_oe_n,
  input wire logic o_int6
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  pins_low_a:
    assert property (!o_scl && !o_sda) else $error("pad data high");
  rd_idle_a:
    assert property (!i_reg_rd |-> o_reg_rdata == 8'h00)
    else $error("rdata without read");
  unmapped_a:
    assert property (i_reg_rd && i_reg_addr == 16'hFF86
      |-> o_reg_rdata == 8'h00) else $error("unmapped read");
  csr_rsv_a:
    assert property (i_reg_rd && i_reg_addr == `I2CM_ADDR_CSR
      |-> o_reg_rdata[7:3] == 5'h00) else $error("csr spare bits");
  int_rsv_a:
    assert property (i_reg_rd && i_reg_addr == `I2CM_ADDR_INT6
      |-> o_reg_rdata[7:4] == 4'h0 && o_reg_rdata[1:0] == 2'h0)
    else $error("int6 spare bits");
  int_off_a:
    assert property (i_reg_wr && i_reg_addr == `I2CM_ADDR_INT6
      && !i_reg_wdata[3] |=> !o_int6) else $error("masked irq high");
  start_go_a:
    assert property (o_int6 && i_reg_wr && i_reg_addr == `I2CM_ADDR_CSR
      && i_reg_wdata[1] |=> !o_int6 ##[0:99] !o_sda_oe_n)
    else $error("start missing");
  done_idle_a:
    assert property (o_int6 |-> o_scl_oe_n && o_sda_oe_n)
    else $error("irq with bus held");
  tick_pace_a:
    assert property ($changed(o_scl_oe_n) || $changed(o_sda_oe_n)
      |-> $past(i_tick_400k)) else $error("bus moved without tick");
  sda_hold_a:
    assert property ($rose(o_scl_oe_n) |-> $stable(o_sda_oe_n))
    else $error("sda moved at scl rise");
endmodule : i2cm_asserts

//--- i2cm_slave_model.sv
// Purpose: behavioural i2c slave on the far side of the bus
// Assumes: pulled-up open-drain wires, oe low pulls low
// Notes: logs every byte, answers reads from i_rd_word
`timescale 1ns/10ps
module i2cm_slave_model
(
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_nack,
  input wire logic [15:0] i_rd_word,
  output logic o_sda_oe_n,
  output logic [23:0] o_log,
  output logic [1:0] o_mack,
  output logic o_busy
);
  logic [7:0] sh;
  logic rd;
  // set once the master declines a read byte; the slave then lets go of sda
  logic quit;
  int bitn;
  int nbyte;
  initial
  begin
    o_sda_oe_n = 1'b1;
    o_busy = 1'b0;
  end
  always @(negedge i_sda)
  begin
    if (i_scl)
    begin
      o_busy = 1'b1;
      bitn = 0;
      nbyte = 0;
      rd = 1'b0;
      quit = 1'b0;
    end
  end
  always @(posedge i_sda)
    if (i_scl) o_busy = 1'b0;
  always @(posedge i_scl)
  begin
    if (o_busy)
    begin
      if (bitn < 8) sh = {sh[6:0], i_sda};
      else if (rd)
      begin
        o_mack = {o_mack[0], i_sda};
        if (nbyte > 0 && i_sda) quit = 1'b1;
      end
      bitn++;
    end
  end
  // ack slot after each byte, then data bits msb first on reads
  always @(negedge i_scl)
  begin
    if (o_busy)
    begin
      if (bitn == 8)
      begin
        if (nbyte == 0) rd = sh[0];
        o_log = {o_log[15:0], sh};
        o_sda_oe_n = (rd && nbyte > 0) | i_nack;
      end
      else
      begin
        if (bitn == 9)
        begin
          bitn = 0;
          nbyte++;
        end
        o_sda_oe_n = (rd && nbyte > 0 && !quit)
          ? i_rd_word[23-8*nbyte-bitn] : 1'b1;
      end
    end
  end
endmodule : i2cm_slave_model

//--- i2c_master_one_two_byte_tb.sv
// Purpose: self-checking bench for the i2c master
// Assumes: tick every 8 clocks, one slave model
// Notes: completion polled through the busy bit
`timescale 1ns/10ps
`include "i2cm_map.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("BAD %s exp %h got %h", nm, e, g); end end
module i2c_master_one_two_byte_tb;
  logic clk, nrst, tick, wr, rd, nack, int6, scl_o, sda_o;
  logic scl_oe_n, sda_oe_n, slv_oe_n, sbusy;
  logic [15:0] addr, rword;
  logic [7:0] wdata, rdata;
  logic [23:0] slog;
  logic [1:0] mack;
  logic [2:0] tc;
  int n_mismatch, num_checks;
  wire scl_w = scl_oe_n;
  wire sda_w = sda_oe_n & slv_oe_n;
  i2cm_top i2cm_top_inst (.i_mclk(clk), .i_nrst(nrst), .i_tick_400k(tick),
    .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .i_scl(scl_w), .i_sda(sda_w), .o_scl(scl_o),
    .o_scl_oe_n(scl_oe_n), .o_sda(sda_o), .o_sda_oe_n(sda_oe_n),
    .o_int6(int6));
  i2cm_slave_model i2cm_slave_model_inst (.i_scl(scl_w), .i_sda(sda_w),
    .i_nack(nack), .i_rd_word(rword), .o_sda_oe_n(slv_oe_n), .o_log(slog),
    .o_mack(mack), .o_busy(sbusy));
  always #5 clk = ~clk;
  always @(negedge clk)
  begin
    tc <= tc + 3'h1;
    tick <= (tc == 3'h7);
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    d = rdata;
    @(negedge clk);
    rd = 1'b0;
  endtask : rd_reg
  task chk_reg(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd_reg(a, v);
    `CHK("reg", e, v)
  endtask : chk_reg
  task wait_done;
    logic [7:0] v;
    for (int k = 0; k < 2000; k++)
    begin
      rd_reg(`I2CM_ADDR_CSR, v);
      if (v[1] === 1'b0) return;
    end
    n_mismatch++;
    $display("BAD wait_done exp idle got busy");
    report_and_stop();
  endtask : wait_done
  task t_reset;
    for (int i = 0; i < 7; i++) chk_reg(16'(16'hFF80 + i), 8'h00);
    chk_reg(`I2CM_ADDR_INT6, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task t_write2;
    wr_reg(`I2CM_ADDR_INT6, 8'h08);
    wr_reg(`I2CM_ADDR_SLAVE, 8'h54);
    wr_reg(`I2CM_ADDR_TX0, 8'hA5);
    wr_reg(`I2CM_ADDR_TX1, 8'h3C);
    wr_reg(`I2CM_ADDR_CSR, 8'h03);
    chk_reg(`I2CM_ADDR_CSR, 8'h03);
    wait_done();
    `CHK("wlog", 24'h54A53C, slog)
    chk_reg(`I2CM_ADDR_CSR, 8'h01);
    chk_reg(`I2CM_ADDR_INT6, 8'h0C);
    `CHK("int6", 1'b1, int6)
    $display("test write2 done");
  endtask : t_write2
  task t_read2;
    rword = 16'hC381;
    wr_reg(`I2CM_ADDR_SLAVE, 8'hA3);
    wr_reg(`I2CM_ADDR_CSR, 8'h03);
    `CHK("int6", 1'b0, int6)
    wait_done();
    `CHK("rlog", 24'hA3C381, slog)
    `CHK("mack", 2'b01, mack)
    chk_reg(`I2CM_ADDR_RX0, 8'hC3);
    chk_reg(`I2CM_ADDR_RX1, 8'h81);
    $display("test read2 done");
  endtask : t_read2
  task t_read1;
    rword = 16'h5A00;
    wr_reg(`I2CM_ADDR_INT6, 8'h00);
    wr_reg(`I2CM_ADDR_CSR, 8'h02);
    wait_done();
    `CHK("nack", 1'b1, mack[0])
    chk_reg(`I2CM_ADDR_RX0, 8'h5A);
    chk_reg(`I2CM_ADDR_RX1, 8'h81);
    chk_reg(`I2CM_ADDR_INT6, 8'h04);
    `CHK("int6", 1'b0, int6)
    $display("test read1 done");
  endtask : t_read1
  task t_nack;
    nack = 1'b1;
    wr_reg(`I2CM_ADDR_INT6, 8'h08);
    wr_reg(`I2CM_ADDR_SLAVE, 8'h54);
    wr_reg(`I2CM_ADDR_CSR, 8'h02);
    wait_done();
    chk_reg(`I2CM_ADDR_CSR, 8'h04);
    `CHK("int6", 1'b1, int6)
    `CHK("stop", 1'b0, sbusy)
    nack = 1'b0;
    $display("test nack done");
  endtask : t_nack
  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    tick = 1'b0;
    tc = 3'h0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 16'h0000;
    wdata = 8'h00;
    nack = 1'b0;
    rword = 16'h0000;
    n_mismatch = 0;
    num_checks = 0;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    t_reset();
    t_write2();
    t_read2();
    t_read1();
    t_nack();
    report_and_stop();
  end
endmodule : i2c_master_one_two_byte_tb
bind i2cm_top i2cm_asserts i2cm_asserts_inst (.i_mclk(i_mclk),
  .i_nrst(i_nrst), .i_tick_400k(i_tick_400k), .i_reg_addr(i_reg_addr),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
  .o_reg_rdata(o_reg_rdata), .i_scl(i_scl), .i_sda(i_sda), .o_scl(o_scl),
  .o_scl_oe_n(o_scl_oe_n), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n),
  .o_int6(o_int6));
